//--- ppx_pkg.sv
`default_nettype none
package ppx_pkg;

    // Clock and timing figures
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_NORM_NS = 1000;
    localparam int T_STROBE_COMP_NS = 800;
    localparam int T_DATA_COMP_NS = 200;
    localparam int T_MR_PULSE_NS = 500;
    // Least times round up to whole cycles
    localparam int NORM_CYC = (T_NORM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_COMP_CYC = (T_STROBE_COMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_COMP_CYC = (T_DATA_COMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MR_CYC = (T_MR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 9;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_EVT_FLAGS = 8'h10;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h14;
    localparam logic [7:0] OFS_PAT_ADDR = 8'h18;
    localparam logic [7:0] OFS_PAT_DATA = 8'h1c;

    // Field positions
    localparam int CMD_MASTER_RESET = 0;
    localparam int CMD_OPTION_RESET = 1;
    localparam int CFG_PORT_PARALLEL = 4;

    // Values after reset
    localparam logic [4:0] CONFIG_RESET = 5'h00;
    localparam logic [3:0] EVT_RESET = 4'h0;

    typedef struct packed {
        logic port_parallel;            // Software port choice
        logic low_byte_first_select;
        logic compressed_timing_select;
        logic busy_option_two;
        logic busy_option_one;
    } ppx_cfg_t;

    typedef struct packed {
        logic bus_init;
        logic sw_test;
        logic sw_reset_pos;
        logic sw_force_option;
        logic sw_test_plot;
        logic device_ack_n;
        logic device_busy;
        logic paper_out;
        logic device_online;
        logic device_fault_n;
    } ppx_pins_t;

    localparam ppx_pins_t PINS_RESET = 10'h011;  // Idle levels: acknowledge and fault high

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_SETUP = 2'b01,
        ENG_STROBE = 2'b10,
        ENG_HOLD = 2'b11
    } ppx_eng_t;

    typedef enum logic {
        EX_IDLE = 1'b0,
        EX_RUN = 1'b1
    } ppx_ex_t;

endpackage : ppx_pkg
`default_nettype wire

//--- ppx_port.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - From test switch in test until reset position, repeatedly send pattern memory bytes to selected port.
// - Reset switch position stops exerciser; centre-off afterwards leaves it idle.
// - Bus init or board switch reset selects the plotter port.
// - Force position of port switch selects the parallel printer port.
// - Test-plot position at start selects plotter, drops print mode, sends all ones.
// - Plotter uses upper 256 pattern bytes, parallel port the lower half.
// - Strobe low one microsecond normally, 800 ns in compressed timing.
// - Data stable one microsecond, or 200 ns compressed, before and after strobe.
// - Eight data outputs active high, top line carries the byte's MSB.
// - Device not ready from strobe fall until acknowledge rising edge.
// - After acknowledge completes, next byte may go unless busy is asserted.
// - Far device raises busy when full; with busy option one set, no strobe issued while busy high.
// - Configuration can make handshake ignore busy entirely.
// - Enableable events on busy rising and paper-out assertion.
// - Enableable events on online dropping and fault assertion.
// - Paper-out and online active high, fault input active low.
// - Device reset out asserts on bus init, master-reset command or option-reset bit.
// - Master-reset command gives one device reset pulse of about 500 ns.
// - Device reset held while option-reset bit stays set.
// - Busy option one: not ready whenever busy asserted.
// - Busy option two: busy from busy rise until acknowledge trailing edge.
// - Configuration picks normal or compressed strobe and data timing.
// - Configuration picks low or high byte of each word sent first.
module ppx_port
    import ppx_pkg::*;
(
    input wire logic CLOCK,                      // 250 MHz clock
    input wire logic RESET,                      // Synchronous reset, active high
    input wire logic BUS_INIT,                   // System bus init, active high
    input wire logic [7:0] REG_ADDR,             // Register byte address
    input wire logic [31:0] REG_WDATA,           // Register write data
    input wire logic REG_WRITE,                  // Write strobe
    input wire logic REG_READ,                   // Read strobe
    output logic [31:0] REG_RDATA,               // Read data, cycle after read
    input wire logic SW_TEST,                    // Reset-test switch in test
    input wire logic SW_RESET_POS,               // Reset-test switch in reset
    input wire logic SW_FORCE_OPTION,            // Port switch in force position
    input wire logic SW_TEST_PLOT,               // Port switch in test-plot position
    input wire logic DEVICE_ACK_N,               // Acknowledge, active low
    input wire logic DEVICE_BUSY,                // Busy, active high
    input wire logic PAPER_OUT,                  // Paper out, active high
    input wire logic DEVICE_ONLINE,              // Online, active high
    input wire logic DEVICE_FAULT_N,             // Device error, active low
    output logic [7:0] PARALLEL_DATA_LINES,      // Data, bit 7 is MSB line
    output logic DATA_STROBE_N,                  // Data strobe, active low
    output logic DEVICE_RESET_N,                 // Device reset, active low
    output logic PRINT_MODE,                     // Low selects plot mode
    output logic PORT_PLOTTER,                   // High while plotter port selected
    output logic [7:0] PLOT_DATA,                // Exerciser byte to plotter port
    output logic PLOT_VALID,                     // Plotter byte offered
    input wire logic PLOT_READY,                 // Plotter port takes byte
    output logic EVENT_PENDING                   // Any enabled event flag set
);

    function automatic logic [CNT_W-1:0] phase_load(input logic comp, input int comp_cyc);
        phase_load = comp ? CNT_W'(comp_cyc - 1) : CNT_W'(NORM_CYC - 1);
    endfunction : phase_load

    ppx_pins_t sync1_reg, sync2_reg, prev_reg;
    ppx_cfg_t cfg_reg, cfg_next;
    ppx_eng_t eng_state_reg, eng_state_next;
    ppx_ex_t ex_state_reg, ex_state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [7:0] data_reg, data_next;
    logic strobe_n_reg, strobe_n_next;
    logic ack_pend_reg, ack_pend_next;
    logic busy_hold_reg, busy_hold_next;
    logic [15:0] word_reg, word_next;
    logic word_full_reg, word_full_next;
    logic half_reg, half_next;
    logic [7:0] ex_addr_reg, ex_addr_next;
    logic plot_test_reg, plot_test_next;
    logic port_plotter_reg, port_plotter_next;
    logic or_reg, or_next;
    logic [CNT_W-1:0] mr_cnt_reg, mr_cnt_next;
    logic reset_n_reg, reset_n_next;
    logic [3:0] flags_reg, flags_next, en_reg, en_next;
    logic [8:0] pat_addr_reg, pat_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] pat_mem [0:511];

    logic ack_rise, busy_rise, ready, sel_parallel, ex_adv, ex_take, sw_take;
    logic wr_cfg, wr_cmd, wr_data, wr_flags, wr_en, wr_paddr, wr_pdata;
    logic [7:0] ex_byte, sw_byte;
    logic [3:0] evt_set;

    // Two-stage synchronisers for all pins and switches
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            sync1_reg <= PINS_RESET;
            sync2_reg <= PINS_RESET;
            prev_reg <= PINS_RESET;
        end else begin
            sync1_reg <= {BUS_INIT, SW_TEST, SW_RESET_POS, SW_FORCE_OPTION, SW_TEST_PLOT,
                          DEVICE_ACK_N, DEVICE_BUSY, PAPER_OUT, DEVICE_ONLINE, DEVICE_FAULT_N};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Edges and handshake readiness
    assign ack_rise = sync2_reg.device_ack_n && !prev_reg.device_ack_n;
    assign busy_rise = sync2_reg.device_busy && !prev_reg.device_busy;
    assign ready = !ack_pend_reg
        && !(cfg_reg.busy_option_one && sync2_reg.device_busy)
        && !(cfg_reg.busy_option_two && busy_hold_reg);
    assign sel_parallel = !plot_test_reg
        && (sync2_reg.sw_force_option || !port_plotter_reg);
    assign ex_byte = plot_test_reg ? 8'hff : pat_mem[{!sel_parallel, ex_addr_reg}];
    assign sw_byte = (cfg_reg.low_byte_first_select ^ half_reg) ? word_reg[7:0]
        : word_reg[15:8];
    assign ex_take = (eng_state_reg == ENG_IDLE) && ready && (ex_state_reg == EX_RUN)
        && sel_parallel;
    assign sw_take = (eng_state_reg == ENG_IDLE) && ready && (ex_state_reg == EX_IDLE)
        && word_full_reg && sel_parallel;
    assign ex_adv = ex_take || (PLOT_VALID && PLOT_READY);

    // Register strobe decode
    assign wr_cfg = REG_WRITE && (REG_ADDR == OFS_CONFIG);
    assign wr_cmd = REG_WRITE && (REG_ADDR == OFS_COMMAND);
    assign wr_data = REG_WRITE && (REG_ADDR == OFS_DATA);
    assign wr_flags = REG_WRITE && (REG_ADDR == OFS_EVT_FLAGS);
    assign wr_en = REG_WRITE && (REG_ADDR == OFS_EVT_ENABLE);
    assign wr_paddr = REG_WRITE && (REG_ADDR == OFS_PAT_ADDR);
    assign wr_pdata = REG_WRITE && (REG_ADDR == OFS_PAT_DATA);

    // Strobe engine: setup, strobe low, hold
    always_comb begin
        eng_state_next = eng_state_reg;
        cnt_next = cnt_reg;
        data_next = data_reg;
        strobe_n_next = strobe_n_reg;
        ack_pend_next = ack_pend_reg;
        busy_hold_next = busy_hold_reg;
        word_next = word_reg;
        word_full_next = word_full_reg;
        half_next = half_reg;
        if (ack_rise) begin
            ack_pend_next = 1'b0;
            busy_hold_next = 1'b0;
        end
        if (busy_rise) begin
            busy_hold_next = 1'b1;
        end
        if (wr_data && !word_full_reg) begin
            word_next = REG_WDATA[15:0];
            word_full_next = 1'b1;
            half_next = 1'b0;
        end
        unique case (eng_state_reg)
            ENG_IDLE: begin
                if (ex_take || sw_take) begin
                    data_next = ex_take ? ex_byte : sw_byte;
                    cnt_next = phase_load(cfg_reg.compressed_timing_select, DATA_COMP_CYC);
                    eng_state_next = ENG_SETUP;
                    if (sw_take) begin
                        half_next = !half_reg;
                        word_full_next = !half_reg;
                    end
                end
            end
            ENG_SETUP: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (ready) begin
                    strobe_n_next = 1'b0;
                    ack_pend_next = 1'b1;
                    cnt_next = phase_load(cfg_reg.compressed_timing_select, STROBE_COMP_CYC);
                    eng_state_next = ENG_STROBE;
                end
            end
            ENG_STROBE: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    strobe_n_next = 1'b1;
                    cnt_next = phase_load(cfg_reg.compressed_timing_select, DATA_COMP_CYC);
                    eng_state_next = ENG_HOLD;
                end
            end
            ENG_HOLD: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    eng_state_next = ENG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            eng_state_reg <= ENG_IDLE;
            cnt_reg <= '0;
            data_reg <= 8'h00;
            strobe_n_reg <= 1'b1;
            ack_pend_reg <= 1'b0;
            busy_hold_reg <= 1'b0;
            word_reg <= 16'h0000;
            word_full_reg <= 1'b0;
            half_reg <= 1'b0;
        end else begin
            eng_state_reg <= eng_state_next;
            cnt_reg <= cnt_next;
            data_reg <= data_next;
            strobe_n_reg <= strobe_n_next;
            ack_pend_reg <= ack_pend_next;
            busy_hold_reg <= busy_hold_next;
            word_reg <= word_next;
            word_full_reg <= word_full_next;
            half_reg <= half_next;
        end
    end

    // Exerciser run control and pattern address
    always_comb begin
        ex_state_next = ex_state_reg;
        ex_addr_next = ex_addr_reg;
        plot_test_next = plot_test_reg;
        if (sync2_reg.sw_reset_pos) begin
            ex_state_next = EX_IDLE;
            plot_test_next = 1'b0;
        end else begin
            unique case (ex_state_reg)
                EX_IDLE: begin
                    if (sync2_reg.sw_test) begin
                        ex_state_next = EX_RUN;
                        ex_addr_next = 8'h00;
                        plot_test_next = sync2_reg.sw_test_plot;
                    end
                end
                EX_RUN: begin
                    if (ex_adv) begin
                        ex_addr_next = ex_addr_reg + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ex_state_reg <= EX_IDLE;
            ex_addr_reg <= 8'h00;
            plot_test_reg <= 1'b0;
        end else begin
            ex_state_reg <= ex_state_next;
            ex_addr_reg <= ex_addr_next;
            plot_test_reg <= plot_test_next;
        end
    end

    // Events, port choice, device reset and register reads
    always_comb begin
        cfg_next = cfg_reg;
        en_next = en_reg;
        or_next = or_reg;
        mr_cnt_next = (mr_cnt_reg != '0) ? mr_cnt_reg - 1'b1 : mr_cnt_reg;
        pat_addr_next = pat_addr_reg;
        port_plotter_next = port_plotter_reg;
        evt_set = {!sync2_reg.device_fault_n && prev_reg.device_fault_n,
                   !sync2_reg.device_online && prev_reg.device_online,
                   sync2_reg.paper_out && !prev_reg.paper_out,
                   busy_rise};
        flags_next = (flags_reg & ~(wr_flags ? REG_WDATA[3:0] : 4'h0)) | evt_set;
        if (wr_cfg) begin
            cfg_next = ppx_cfg_t'(REG_WDATA[4:0]);
            port_plotter_next = !REG_WDATA[CFG_PORT_PARALLEL];
        end
        if (wr_en) begin
            en_next = REG_WDATA[3:0];
        end
        if (wr_cmd) begin
            or_next = REG_WDATA[CMD_OPTION_RESET];
            if (REG_WDATA[CMD_MASTER_RESET]) begin
                mr_cnt_next = CNT_W'(MR_CYC);
            end
        end
        if (wr_paddr) begin
            pat_addr_next = REG_WDATA[8:0];
        end else if (wr_pdata) begin
            pat_addr_next = pat_addr_reg + 9'h001;
        end
        if (ex_state_reg == EX_IDLE && ex_state_next == EX_RUN && sync2_reg.sw_test_plot) begin
            port_plotter_next = 1'b1;
        end
        if (sync2_reg.bus_init || sync2_reg.sw_reset_pos) begin
            port_plotter_next = 1'b1;
        end
        reset_n_next = !(sync2_reg.bus_init || (mr_cnt_reg != '0) || or_reg);
        rdata_next = 32'h0000_0000;
        if (REG_READ) begin
            unique case (REG_ADDR)
                OFS_CONFIG: rdata_next = {27'h0, cfg_reg};
                OFS_COMMAND: rdata_next = {30'h0, or_reg, 1'b0};
                OFS_DATA: rdata_next = {15'h0, word_full_reg, word_reg};
                OFS_STATUS: rdata_next = {21'h0, !reset_n_reg, plot_test_reg,
                    ex_state_reg == EX_RUN, !sel_parallel, word_full_reg, ready,
                    sync2_reg.device_ack_n, !sync2_reg.device_fault_n,
                    sync2_reg.device_online, sync2_reg.paper_out, sync2_reg.device_busy};
                OFS_EVT_FLAGS: rdata_next = {28'h0, flags_reg};
                OFS_EVT_ENABLE: rdata_next = {28'h0, en_reg};
                OFS_PAT_ADDR: rdata_next = {23'h0, pat_addr_reg};
                OFS_PAT_DATA: rdata_next = {24'h0, pat_mem[pat_addr_reg]};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfg_reg <= CONFIG_RESET;
            en_reg <= EVT_RESET;
            flags_reg <= EVT_RESET;
            or_reg <= 1'b0;
            mr_cnt_reg <= '0;
            pat_addr_reg <= 9'h000;
            port_plotter_reg <= 1'b1;
            reset_n_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            cfg_reg <= cfg_next;
            en_reg <= en_next;
            flags_reg <= flags_next;
            or_reg <= or_next;
            mr_cnt_reg <= mr_cnt_next;
            pat_addr_reg <= pat_addr_next;
            port_plotter_reg <= port_plotter_next;
            reset_n_reg <= reset_n_next;
            rdata_reg <= rdata_next;
        end
    end

    // Pattern memory, loaded by software
    always_ff @(posedge CLOCK) begin
        if (wr_pdata) begin
            pat_mem[pat_addr_reg] <= REG_WDATA[7:0];
        end
    end

    // Outputs
    assign PARALLEL_DATA_LINES = data_reg;
    assign DATA_STROBE_N = strobe_n_reg;
    assign DEVICE_RESET_N = reset_n_reg;
    assign PRINT_MODE = !plot_test_reg;
    assign PORT_PLOTTER = !sel_parallel;
    assign PLOT_DATA = ex_byte;
    assign PLOT_VALID = (ex_state_reg == EX_RUN) && !sel_parallel;
    assign EVENT_PENDING = |(flags_reg & en_reg);
    assign REG_RDATA = rdata_reg;

    // Helper: cycles spent in current engine phase
    logic [CNT_W-1:0] phase_len_reg;
    always_ff @(posedge CLOCK) begin
        if (RESET || eng_state_next != eng_state_reg) begin
            phase_len_reg <= '0;
        end else begin
            phase_len_reg <= phase_len_reg + 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_strobe_width: assert property ((eng_state_reg == ENG_STROBE && eng_state_next == ENG_HOLD)
        |-> phase_len_reg == (cfg_reg.compressed_timing_select ? CNT_W'(STROBE_COMP_CYC - 1)
        : CNT_W'(NORM_CYC - 1))) else $error("strobe width wrong");
    a_hold_time: assert property ((eng_state_reg == ENG_HOLD && eng_state_next == ENG_IDLE)
        |-> phase_len_reg == (cfg_reg.compressed_timing_select ? CNT_W'(DATA_COMP_CYC - 1)
        : CNT_W'(NORM_CYC - 1))) else $error("hold time wrong");
    a_setup_time: assert property ((eng_state_reg == ENG_SETUP && eng_state_next == ENG_STROBE)
        |-> phase_len_reg >= (cfg_reg.compressed_timing_select ? CNT_W'(DATA_COMP_CYC - 1)
        : CNT_W'(NORM_CYC - 1))) else $error("setup too short");
    a_data_stable: assert property ($changed(PARALLEL_DATA_LINES)
        |-> $past(eng_state_reg) == ENG_IDLE) else $error("data moved mid transfer");
    a_busy_blocks: assert property ($fell(DATA_STROBE_N)
        |-> !($past(cfg_reg.busy_option_one) && $past(sync2_reg.device_busy)))
        else $error("strobe while busy");
    a_ack_wait: assert property ($fell(DATA_STROBE_N) |-> !$past(ack_pend_reg) && ack_pend_reg)
        else $error("strobe before ack");
    a_mr_pulse: assert property ((wr_cmd && REG_WDATA[CMD_MASTER_RESET])
        |-> ##2 !DEVICE_RESET_N [*8]) else $error("master reset pulse missing");
    a_or_hold: assert property (or_reg |=> !DEVICE_RESET_N) else $error("option reset dropped");
    a_init_port: assert property (sync2_reg.bus_init |=> port_plotter_reg)
        else $error("init did not pick plotter");
    a_ex_stop: assert property (sync2_reg.sw_reset_pos |=> ex_state_reg == EX_IDLE)
        else $error("exerciser not stopped");
    a_ex_wrap: assert property ((ex_state_reg == EX_RUN && ex_adv && ex_addr_reg == 8'hff
        && !sync2_reg.sw_reset_pos) |=> ex_addr_reg == 8'h00) else $error("no wrap");
    a_plot_ones: assert property (plot_test_reg |-> PLOT_DATA == 8'hff && !PRINT_MODE
        && PORT_PLOTTER) else $error("plot test data wrong");
    a_busy_event: assert property (busy_rise |=> flags_reg[0]) else $error("busy event lost");

    c_strobe: cover property ($rose(DATA_STROBE_N));
    c_ex_parallel: cover property (ex_take);
    c_plot_test: cover property (plot_test_reg && PLOT_VALID && PLOT_READY);
    c_mr_pulse: cover property ($rose(DEVICE_RESET_N));

endmodule : ppx_port
`default_nettype wire

//--- ppx_printer_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppx_printer_model (
    input wire logic clk, // Board clock
    input wire logic strobe_n, // Strobe, active low
    input wire logic [7:0] data, // Data lines
    output logic ack_n = 1'b1 // Acknowledge, active low
);
    int stab = 0, cnt = 0, low_cyc, setup_cyc;
    logic [7:0] got, last;
    // Cycles since the data lines last moved, counted at falling edges
    always @(negedge clk) begin
        stab = (data === last) ? stab + 1 : 1;
        last = data;
    end
    // Take a byte at strobe fall, acknowledge once the strobe rises
    initial forever begin
        @(negedge strobe_n);
        setup_cyc = stab;
        got = data;
        low_cyc = 0;
        while (strobe_n !== 1'b1) begin
            @(negedge clk);
            low_cyc += int'(strobe_n === 1'b0);
        end
        ack_n = 1'b0;
        repeat (60) @(negedge clk);
        ack_n = 1'b1;
        cnt++;
    end
endmodule : ppx_printer_model
`default_nettype wire

//--- tb_ppx_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ppx_port
    import ppx_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack_n, stb_n, rst_n, plt, pend;
    logic pm, pv, prdy = 1'b1;
    logic [7:0] addr = 8'h00, pd, pdat;
    logic [31:0] wd = 32'h0, rdata, d, w;
    ppx_pins_t pins = 10'h003;
    int exp_q[$];
    int comparisons = 0, miscompares = 0, seed = 32'h29f5ce28, i, k;
    ppx_port dut_u (.CLOCK(clk), .RESET(rst), .BUS_INIT(pins.bus_init), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata),
        .SW_TEST(pins.sw_test), .SW_RESET_POS(pins.sw_reset_pos),
        .SW_FORCE_OPTION(pins.sw_force_option), .SW_TEST_PLOT(pins.sw_test_plot),
        .DEVICE_ACK_N(ack_n), .DEVICE_BUSY(pins.device_busy), .PAPER_OUT(pins.paper_out),
        .DEVICE_ONLINE(pins.device_online), .DEVICE_FAULT_N(pins.device_fault_n),
        .PARALLEL_DATA_LINES(pd), .DATA_STROBE_N(stb_n), .DEVICE_RESET_N(rst_n),
        .PRINT_MODE(pm), .PORT_PLOTTER(plt), .PLOT_DATA(pdat), .PLOT_VALID(pv),
        .PLOT_READY(prdy),
        .EVENT_PENDING(pend));
    ppx_printer_model model_u (.clk(clk), .strobe_n(stb_n), .data(pd), .ack_n(ack_n));
    // Clock, 4 ns period
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        @(negedge clk);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Bounded wait for the partner's n-th byte; running out ends the run as a failure
    task automatic wait_cnt(input int n);
        for (int t = 0; t < 3000 && model_u.cnt < n; t++) @(posedge clk);
        if (model_u.cnt != n) begin
            miscompares++;
            wrap_up();
        end
    endtask : wait_cnt
    // One register access, write or read; read data lands in d
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {addr, wd, wr, rd} <= {a, v, we, !we};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(negedge clk);
        d = rdata;
    endtask : bus
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(plt, 1);
        @(posedge clk) pins.sw_force_option <= 1'b1;
        repeat (4) @(posedge clk);
        chk(plt, 0);
        @(posedge clk) pins.sw_force_option <= 1'b0;
        bus(0, 8'hfc, 0);
        chk(d, 0);
        for (k = 0; k < 2; k++) begin
            repeat (300) @(posedge clk);
            bus(1, OFS_CONFIG, k ? 32'h14 : 32'h18);
            w = $random(seed);
            exp_q.push_back(k ? w[15:8] : w[7:0]);
            exp_q.push_back(k ? w[7:0] : w[15:8]);
            bus(1, OFS_DATA, {16'h0, w[15:0]});
            for (i = 0; i < 2; i++) begin
                wait_cnt(2 * k + i + 1);
                chk(model_u.got, exp_q.pop_front());
                chk(model_u.low_cyc, k ? STROBE_COMP_CYC : NORM_CYC);
                chk(model_u.setup_cyc >= (k ? DATA_COMP_CYC : NORM_CYC), 1);
            end
        end
        // Busy option one holds a word back; with both options off busy is ignored
        w = $random(seed);
        @(posedge clk) pins.device_busy <= 1'b1;
        bus(1, OFS_CONFIG, 32'h15);
        bus(1, OFS_DATA, w);
        repeat (400) @(posedge clk);
        chk(model_u.cnt, 4);
        bus(1, OFS_CONFIG, 32'h14);
        wait_cnt(5);
        chk(model_u.got, w[15:8]);
        wait_cnt(6);
        chk(model_u.got, w[7:0]);
        // Pattern: one upper-half byte for the plotter, four lower-half bytes
        @(posedge clk) pins.device_busy <= 1'b0;
        bus(1, OFS_PAT_ADDR, 32'h100);
        k = $random(seed);
        bus(1, OFS_PAT_DATA, k);
        bus(1, OFS_PAT_ADDR, 0);
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            bus(1, OFS_PAT_DATA, w);
            if (i < 3) exp_q.push_back(w[7:0]);
        end
        // Exerciser on the parallel port, then reset position and centre-off
        @(posedge clk) pins.sw_test <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wait_cnt(7 + i);
            chk(model_u.got, exp_q.pop_front());
        end
        @(posedge clk) pins <= 10'h083;
        repeat (4) @(posedge clk);
        bus(0, OFS_STATUS, 0);
        chk(d[8:7], 2'b01);
        @(posedge clk) pins <= 10'h003;
        repeat (4) @(posedge clk);
        bus(0, OFS_STATUS, 0);
        chk(d[8], 0);
        // Plot test: all ones, print mode off, plotter port selected
        @(posedge clk) pins <= 10'h123;
        repeat (300) @(posedge clk);
        chk({pm, pv, plt, pdat}, 11'h3ff);
        // Plotter run held by a not-ready plotter shows upper-half byte 0
        @(posedge clk) {pins, prdy} <= {10'h083, 1'b0};
        repeat (4) @(posedge clk);
        @(posedge clk) pins <= 10'h103;
        repeat (6) @(posedge clk);
        chk({pm, pv, pdat}, {2'b11, k[7:0]});
        @(posedge clk) pins <= 10'h083;
        repeat (4) @(posedge clk);
        bus(1, OFS_EVT_ENABLE, 32'h2);
        @(posedge clk) pins <= 10'h006;
        repeat (6) @(posedge clk);
        chk(pend, 1);
        bus(0, OFS_EVT_FLAGS, 0);
        chk(d, 32'hb);
        bus(1, OFS_EVT_FLAGS, 32'h2);
        chk(pend, 0);
        bus(1, OFS_COMMAND, 32'h1);
        k = 0;
        for (i = 0; i < 300; i++) begin @(negedge clk); k += int'(!rst_n); end
        chk(k, MR_CYC);
        bus(1, OFS_COMMAND, 32'h2);
        repeat (300) @(posedge clk);
        chk(rst_n, 0);
        bus(1, OFS_COMMAND, 32'h0);
        repeat (3) @(posedge clk);
        chk(rst_n, 1);
        @(posedge clk) pins.bus_init <= 1'b1;
        repeat (6) @(posedge clk);
        chk(rst_n, 0);
        chk(plt, 1);
        wrap_up();
    end
endmodule : tb_ppx_port
`default_nettype wire
